/* design/ntbdw_pkg.sv */
package ntbdw_pkg;

  // register byte offsets inside the bridge control space
  localparam logic [15:0] OFF_W2_SETUP = 16'h000c;
  localparam logic [15:0] OFF_W3_TBASE = 16'h0010;
  localparam logic [15:0] OFF_W3_SETUP = 16'h0014;
  localparam logic [15:0] OFF_W3_UPPER = 16'h0018;

  // setup register fields
  localparam int TYPE_SEL_BIT  = 0;
  localparam int ADDR_TYPE_LSB = 1;
  localparam int ADDR_TYPE_MSB = 2;
  localparam int PREFETCH_BIT  = 3;
  localparam int SIZE_LSB      = 12;
  localparam int SIZE_MSB      = 30;
  localparam int ENABLE_BIT    = 31;

  // translated base and upper setup fields
  localparam int TBASE_LSB       = 12;
  localparam int UPPER_SIZE_MSB  = 30;
  localparam int UPPER_ENABLE_BIT = 31;

  localparam logic [1:0] ADDR_TYPE_32 = 2'h0;
  localparam logic [1:0] ADDR_TYPE_64 = 2'h1;

  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] TBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] UPPER_RESET = 32'h0000_0000;

  // ones mark the bits that can hold a written value
  localparam logic [31:0] SETUP_WMASK = 32'hffff_f00e;
  localparam logic [31:0] TBASE_WMASK = 32'hffff_f000;
  localparam logic [31:0] UPPER_WMASK = 32'hffff_ffff;

  typedef enum logic [1:0] {
    PORT_NONE,
    PORT_PRI,
    PORT_SEC
  } ntbdw_port_type;

endpackage

/* design/ntbdw_field_reg.sv */
`timescale 1ns/10ps
module ntbdw_field_reg #(
  parameter logic [31:0] WMASK = 32'hffff_ffff,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  output logic      [31:0] q
);

  logic [31:0] val_q;
  logic [31:0] val_d;

  // bits outside the mask never change, so they keep reading zero
  always_comb begin
    val_d = val_q;
    for (int i = 0; i < 4; i++) begin
      if (wr_en && be[i]) begin
        val_d[8*i +: 8] = (wdata[8*i +: 8] & WMASK[8*i +: 8]) |
                          (val_q[8*i +: 8] & ~WMASK[8*i +: 8]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= RESET & WMASK;
    end else begin
      val_q <= val_d;
    end
  end

  assign q = val_q;

endmodule

/* design/ntbdw_top.sv */
`timescale 1ns/10ps
// What this block does
// [RL1] setup bit 0 reads zero, memory space
// [RL2] bits 2:1 pick 32/64-bit, bit 3 prefetch
// [RL3] size bits 30:12 mask base address writability
// [RL4] setup bit 31 enables the window decode
// [RL5] window 3 translated base in bits 31:12
// [RL6] translate only the decoded address bits
// [RL7] upper setup bits 30:0 mask upper base
// [RL8] upper setup bit 31 enables 64-bit base
// [RL9] secondary-writable fields: writable only from secondary
// [RL10] both bridge ports reach these registers
// [RL11] reserved bits read zero, ignore writes
module ntbdw_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              pri_req,
  input  wire logic              pri_write,
  input  wire logic [ADDR_W-1:0] pri_addr,
  input  wire logic [3:0]        pri_be,
  input  wire logic [31:0]       pri_wdata,
  output logic      [31:0]       pri_rdata,
  output logic                   pri_ack,
  input  wire logic              sec_req,
  input  wire logic              sec_write,
  input  wire logic [ADDR_W-1:0] sec_addr,
  input  wire logic [3:0]        sec_be,
  input  wire logic [31:0]       sec_wdata,
  output logic      [31:0]       sec_rdata,
  output logic                   sec_ack,
  output logic      [31:0]       w2_bar_wmask,
  output logic                   w2_enable,
  output logic                   w2_addr64,
  output logic                   w2_prefetch,
  output logic      [31:0]       w3_bar_wmask,
  output logic                   w3_enable,
  output logic                   w3_addr64,
  output logic                   w3_prefetch,
  output logic      [31:0]       w3_upper_wmask,
  output logic                   w3_upper_enable,
  input  wire logic              xl_valid,
  input  wire logic [31:0]       xl_addr_lo,
  input  wire logic [31:0]       xl_addr_hi,
  input  wire logic [31:0]       w3_base_lo,
  input  wire logic [31:0]       w3_base_hi,
  output logic                   xl_done,
  output logic                   xl_hit,
  output logic      [31:0]       xl_addr_out
);

  // the decode needs the dword index and at most a 16-bit offset space
  if (ADDR_W < 5 || ADDR_W > 16) begin : gen_addr_w_check
    $error("ADDR_W must lie between 5 and 16");
  end

  ntbdw_pkg::ntbdw_port_type grant;

  logic              sel_write;
  logic [ADDR_W-1:0] sel_addr;
  logic [3:0]        sel_be;
  logic [31:0]       sel_wdata;
  logic              hit_w2s;
  logic              hit_w3t;
  logic              hit_w3s;
  logic              hit_w3u;
  logic              from_sec;
  logic [31:0]       w2_setup;
  logic [31:0]       w3_tbase;
  logic [31:0]       w3_setup;
  logic [31:0]       w3_upper;
  logic [31:0]       rd_mux;

  logic        pri_ack_q;
  logic        pri_ack_d;
  logic        sec_ack_q;
  logic        sec_ack_d;
  logic [31:0] pri_rdata_q;
  logic [31:0] pri_rdata_d;
  logic [31:0] sec_rdata_q;
  logic [31:0] sec_rdata_d;

  // a port that was just answered is not taken again in the answer cycle,
  // so a requester holding its request until the ack never doubles up
  // [RL10] primary first
  always_comb begin
    if (pri_req && !pri_ack_q) begin
      grant = ntbdw_pkg::PORT_PRI;
    end else if (sec_req && !sec_ack_q) begin
      grant = ntbdw_pkg::PORT_SEC;
    end else begin
      grant = ntbdw_pkg::PORT_NONE;
    end
  end

  always_comb begin
    sel_write = 1'b0;
    sel_addr  = '0;
    sel_be    = 4'h0;
    sel_wdata = 32'h0000_0000;
    from_sec  = 1'b0;
    unique case (grant)
      ntbdw_pkg::PORT_PRI: begin
        sel_write = pri_write;
        sel_addr  = pri_addr;
        sel_be    = pri_be;
        sel_wdata = pri_wdata;
      end
      ntbdw_pkg::PORT_SEC: begin
        sel_write = sec_write;
        sel_addr  = sec_addr;
        sel_be    = sec_be;
        sel_wdata = sec_wdata;
        from_sec  = 1'b1;
      end
      ntbdw_pkg::PORT_NONE: begin
        sel_write = 1'b0;
      end
      default: begin
        sel_write = 1'b0;
      end
    endcase
  end

  // dword decode; byte lanes come from the enables
  always_comb begin
    hit_w2s = (grant != ntbdw_pkg::PORT_NONE) &&
              (sel_addr[ADDR_W-1:2] == (ADDR_W-2)'(ntbdw_pkg::OFF_W2_SETUP >> 2));
    hit_w3t = (grant != ntbdw_pkg::PORT_NONE) &&
              (sel_addr[ADDR_W-1:2] == (ADDR_W-2)'(ntbdw_pkg::OFF_W3_TBASE >> 2));
    hit_w3s = (grant != ntbdw_pkg::PORT_NONE) &&
              (sel_addr[ADDR_W-1:2] == (ADDR_W-2)'(ntbdw_pkg::OFF_W3_SETUP >> 2));
    hit_w3u = (grant != ntbdw_pkg::PORT_NONE) &&
              (sel_addr[ADDR_W-1:2] == (ADDR_W-2)'(ntbdw_pkg::OFF_W3_UPPER >> 2));
  end

  // [RL1] type bit never stored
  // [RL9] setup written from secondary only
  ntbdw_field_reg #(
    .WMASK (ntbdw_pkg::SETUP_WMASK),
    .RESET (ntbdw_pkg::SETUP_RESET)
  ) u_w2_setup (
    .clk   (clk),
    .rst   (rst),
    .wr_en (sel_write && hit_w2s && from_sec),
    .be    (sel_be),
    .wdata (sel_wdata),
    .q     (w2_setup)
  );

  // [RL5] translated base store
  ntbdw_field_reg #(
    .WMASK (ntbdw_pkg::TBASE_WMASK),
    .RESET (ntbdw_pkg::TBASE_RESET)
  ) u_w3_tbase (
    .clk   (clk),
    .rst   (rst),
    .wr_en (sel_write && hit_w3t),
    .be    (sel_be),
    .wdata (sel_wdata),
    .q     (w3_tbase)
  );

  // [RL9] setup written from secondary only
  ntbdw_field_reg #(
    .WMASK (ntbdw_pkg::SETUP_WMASK),
    .RESET (ntbdw_pkg::SETUP_RESET)
  ) u_w3_setup (
    .clk   (clk),
    .rst   (rst),
    .wr_en (sel_write && hit_w3s && from_sec),
    .be    (sel_be),
    .wdata (sel_wdata),
    .q     (w3_setup)
  );

  // [RL7] upper mask, writable from both
  ntbdw_field_reg #(
    .WMASK (ntbdw_pkg::UPPER_WMASK),
    .RESET (ntbdw_pkg::UPPER_RESET)
  ) u_w3_upper (
    .clk   (clk),
    .rst   (rst),
    .wr_en (sel_write && hit_w3u),
    .be    (sel_be),
    .wdata (sel_wdata),
    .q     (w3_upper)
  );

  // [RL11] unmapped and reserved read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_w2s) begin
      rd_mux = w2_setup;
    end else if (hit_w3t) begin
      rd_mux = w3_tbase;
    end else if (hit_w3s) begin
      rd_mux = w3_setup;
    end else if (hit_w3u) begin
      rd_mux = w3_upper;
    end
  end

  // answer one cycle after the request is taken; writes return zero data
  always_comb begin
    pri_ack_d   = (grant == ntbdw_pkg::PORT_PRI);
    sec_ack_d   = (grant == ntbdw_pkg::PORT_SEC);
    pri_rdata_d = pri_rdata_q;
    sec_rdata_d = sec_rdata_q;
    if (pri_ack_d) begin
      pri_rdata_d = sel_write ? 32'h0000_0000 : rd_mux;
    end
    if (sec_ack_d) begin
      sec_rdata_d = sel_write ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_ack_q   <= 1'b0;
      sec_ack_q   <= 1'b0;
      pri_rdata_q <= 32'h0000_0000;
      sec_rdata_q <= 32'h0000_0000;
    end else begin
      pri_ack_q   <= pri_ack_d;
      sec_ack_q   <= sec_ack_d;
      pri_rdata_q <= pri_rdata_d;
      sec_rdata_q <= sec_rdata_d;
    end
  end

  assign pri_ack   = pri_ack_q;
  assign sec_ack   = sec_ack_q;
  assign pri_rdata = pri_rdata_q;
  assign sec_rdata = sec_rdata_q;

  // window controls seen by the base address registers
  always_comb begin
    // [RL4] enable bits
    w2_enable = w2_setup[ntbdw_pkg::ENABLE_BIT];
    w3_enable = w3_setup[ntbdw_pkg::ENABLE_BIT];
    // [RL2] width and prefetch decode
    w2_addr64 = w2_setup[ntbdw_pkg::ADDR_TYPE_MSB:ntbdw_pkg::ADDR_TYPE_LSB]
                == ntbdw_pkg::ADDR_TYPE_64;
    w3_addr64 = w3_setup[ntbdw_pkg::ADDR_TYPE_MSB:ntbdw_pkg::ADDR_TYPE_LSB]
                == ntbdw_pkg::ADDR_TYPE_64;
    w2_prefetch = w2_setup[ntbdw_pkg::PREFETCH_BIT];
    w3_prefetch = w3_setup[ntbdw_pkg::PREFETCH_BIT];
    // [RL3] size bits as writable mask; top bit always decodes when on
    w2_bar_wmask = 32'h0000_0000;
    w3_bar_wmask = 32'h0000_0000;
    if (w2_enable) begin
      w2_bar_wmask = {1'b1, w2_setup[ntbdw_pkg::SIZE_MSB:ntbdw_pkg::SIZE_LSB], 12'h000};
    end
    if (w3_enable) begin
      w3_bar_wmask = {1'b1, w3_setup[ntbdw_pkg::SIZE_MSB:ntbdw_pkg::SIZE_LSB], 12'h000};
    end
    // [RL8] upper base enable and mask
    w3_upper_enable = w3_upper[ntbdw_pkg::UPPER_ENABLE_BIT];
    w3_upper_wmask  = 32'h0000_0000;
    if (w3_upper_enable) begin
      w3_upper_wmask = {1'b1, w3_upper[ntbdw_pkg::UPPER_SIZE_MSB:0]};
    end
  end

  // window 3 address translation, one registered stage
  logic        xl_done_q;
  logic        xl_done_d;
  logic        xl_hit_q;
  logic        xl_hit_d;
  logic [31:0] xl_addr_q;
  logic [31:0] xl_addr_d;
  logic        lo_match;
  logic        hi_match;

  always_comb begin
    // [RL4] disabled window never matches
    lo_match = w3_enable && (((xl_addr_lo ^ w3_base_lo) & w3_bar_wmask) == 32'h0000_0000);
    if (w3_addr64 && w3_upper_enable) begin
      hi_match = ((xl_addr_hi ^ w3_base_hi) & w3_upper_wmask) == 32'h0000_0000;
    end else begin
      hi_match = (xl_addr_hi == 32'h0000_0000);
    end
    xl_done_d = xl_valid;
    xl_hit_d  = xl_valid && lo_match && hi_match;
    xl_addr_d = xl_addr_q;
    if (xl_valid) begin
      // [RL6] swap decoded bits only
      xl_addr_d = xl_hit_d ? ((w3_tbase & w3_bar_wmask) | (xl_addr_lo & ~w3_bar_wmask))
                           : xl_addr_lo;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xl_done_q <= 1'b0;
      xl_hit_q  <= 1'b0;
      xl_addr_q <= 32'h0000_0000;
    end else begin
      xl_done_q <= xl_done_d;
      xl_hit_q  <= xl_hit_d;
      xl_addr_q <= xl_addr_d;
    end
  end

  assign xl_done     = xl_done_q;
  assign xl_hit      = xl_hit_q;
  assign xl_addr_out = xl_addr_q;

endmodule

/* testbench/ntbdw_checker_assertions.sv */
`timescale 1ns/10ps
module ntbdw_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        pri_req,
  input wire logic        pri_ack,
  input wire logic        sec_req,
  input wire logic        sec_ack,
  input wire logic [31:0] w2_bar_wmask,
  input wire logic        w2_enable,
  input wire logic [31:0] w3_bar_wmask,
  input wire logic        w3_enable,
  input wire logic [31:0] w3_upper_wmask,
  input wire logic        w3_upper_enable,
  input wire logic        xl_valid,
  input wire logic [31:0] xl_addr_lo,
  input wire logic        xl_done,
  input wire logic        xl_hit,
  input wire logic [31:0] xl_addr_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_pri_ack_next: assert property (pri_req && !pri_ack |=> pri_ack)
    else $error("primary request not answered next cycle");
  chk_ack_one_cycle: assert property (pri_ack |=> !pri_ack)
    else $error("primary answer longer than one cycle");
  chk_sec_ack_cause: assert property (sec_ack |-> $past(sec_req))
    else $error("secondary answer without request");
  chk_sec_ack_next: assert property (sec_req && !sec_ack && !(pri_req && !pri_ack) |=> sec_ack)
    else $error("secondary request not answered next cycle");
  chk_w2_mask_off: assert property (!w2_enable |-> w2_bar_wmask == 32'h0000_0000)
    else $error("disabled window 2 has writable bits");
  chk_w3_mask_low: assert property (w3_bar_wmask[11:0] == 12'h000)
    else $error("window 3 mask below bit 12");
  chk_w3_mask_top: assert property (w3_enable == w3_bar_wmask[31])
    else $error("window 3 mask top bit differs from enable");
  chk_upper_mask_top: assert property (w3_upper_enable == w3_upper_wmask[31])
    else $error("upper mask top bit differs from enable");
  chk_xl_done_next: assert property (xl_valid |=> xl_done)
    else $error("translation result late");
  chk_xl_miss_pass: assert property (xl_done && !xl_hit |-> xl_addr_out == $past(xl_addr_lo))
    else $error("missed address changed");
  chk_xl_low_pass: assert property (xl_done |-> (xl_addr_out & ~w3_bar_wmask) == ($past(xl_addr_lo) & ~$past(w3_bar_wmask)))
    else $error("offset bits inside window changed");
  chk_xl_hit_enabled: assert property (xl_hit |-> $past(w3_enable))
    else $error("hit while window 3 disabled");
  cover property (pri_ack);
  cover property (sec_req && pri_req && !pri_ack);
  cover property (xl_done && xl_hit);
endmodule

bind ntbdw_top ntbdw_checker i_ntbdw_checker (.clk, .rst, .pri_req, .pri_ack, .sec_req, .sec_ack,
  .w2_bar_wmask, .w2_enable, .w3_bar_wmask, .w3_enable, .w3_upper_wmask, .w3_upper_enable,
  .xl_valid, .xl_addr_lo, .xl_done, .xl_hit, .xl_addr_out);

/* testbench/ntbdw_top_tb.sv */
`timescale 1ns/10ps
module ntbdw_top_tb;
  logic        clk, rst, pri_req, pri_write, sec_req, sec_write, xl_valid, pri_ack, sec_ack;
  logic        w2_enable, w2_addr64, w2_prefetch, w3_enable, w3_addr64, w3_prefetch, w3_upper_enable;
  logic        xl_done, xl_hit;
  logic [11:0] pri_addr, sec_addr;
  logic [3:0]  pri_be, sec_be;
  logic [31:0] pri_wdata, sec_wdata, xl_addr_lo, xl_addr_hi, w3_base_lo, w3_base_hi, rd;
  logic [31:0] pri_rdata, sec_rdata, w2_bar_wmask, w3_bar_wmask, w3_upper_wmask, xl_addr_out;
  int          mismatches, total_checks;

  ntbdw_top i_ntbdw_top (.clk, .rst, .pri_req, .pri_write, .pri_addr, .pri_be, .pri_wdata, .pri_rdata,
    .pri_ack, .sec_req, .sec_write, .sec_addr, .sec_be, .sec_wdata, .sec_rdata, .sec_ack, .w2_bar_wmask,
    .w2_enable, .w2_addr64, .w2_prefetch, .w3_bar_wmask, .w3_enable, .w3_addr64, .w3_prefetch,
    .w3_upper_wmask, .w3_upper_enable, .xl_valid, .xl_addr_lo, .xl_addr_hi, .w3_base_lo, .w3_base_hi,
    .xl_done, .xl_hit, .xl_addr_out);

  always #25 clk = ~clk;

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task cmp(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the answer is seen; rd stays unknown on a hang so the compare fails
  task acc(input bit s, input bit w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    n = 0;
    rd = 'x;
    @(negedge clk);
    if (s)
      {sec_req, sec_write, sec_addr, sec_be, sec_wdata} = {1'b1, w, a, b, d};
    else
      {pri_req, pri_write, pri_addr, pri_be, pri_wdata} = {1'b1, w, a, b, d};
    do begin
      @(negedge clk);
      n++;
    end while ((s ? sec_ack : pri_ack) !== 1'b1 && n < 8);
    if (n < 8)
      rd = s ? sec_rdata : pri_rdata;
    else
      cmp(64'h0, 64'h1);
    pri_req = 1'b0;
    sec_req = 1'b0;
  endtask

  task wr(input bit s, input logic [11:0] a, input logic [31:0] d);
    acc(s, 1'b1, a, 4'hf, d);
  endtask

  task rdc(input bit s, input logic [11:0] a, input logic [31:0] exp);
    acc(s, 1'b0, a, 4'hf, 32'h0000_0000);
    cmp(rd, exp);
  endtask

  task xl(input logic [31:0] lo, input logic [31:0] hi, input logic h, input logic [31:0] o);
    @(negedge clk);
    {xl_valid, xl_addr_lo, xl_addr_hi} = {1'b1, lo, hi};
    @(negedge clk);
    xl_valid = 1'b0;
    cmp(xl_done, 1'b1);
    cmp(xl_hit, h);
    cmp(xl_addr_out, o);
  endtask

  task t_reset_values;
    for (int i = 0; i < 4; i++)
      rdc(1'b0, 12'h00c + 12'(4 * i), 32'h0000_0000);
    cmp(w3_upper_wmask | w3_bar_wmask | w2_bar_wmask, 32'h0000_0000);
  endtask

  task t_port_access;
    wr(1'b0, 12'h00c, 32'hffff_ffff);
    wr(1'b0, 12'h014, 32'hffff_ffff);
    rdc(1'b0, 12'h00c, 32'h0000_0000);
    rdc(1'b1, 12'h014, 32'h0000_0000);
    wr(1'b0, 12'h018, 32'hffff_ffff);
    rdc(1'b1, 12'h018, 32'hffff_ffff);
    cmp({w3_upper_enable, w3_upper_wmask}, 33'h1_ffff_ffff);
    wr(1'b1, 12'h018, 32'h7fff_ffff);
    cmp({w3_upper_enable, w3_upper_wmask}, 33'h0_0000_0000);
    wr(1'b0, 12'h010, 32'hffff_ffff);
    rdc(1'b1, 12'h010, 32'hffff_f000);
    wr(1'b1, 12'h020, 32'hffff_ffff);
    rdc(1'b1, 12'h020, 32'h0000_0000);
    rdc(1'b0, 12'h008, 32'h0000_0000);
  endtask

  task t_setup_fields;
    wr(1'b1, 12'h00c, 32'hffff_ffff);
    rdc(1'b0, 12'h00c, 32'hffff_f00e);
    cmp(w2_bar_wmask, 32'hffff_f000);
    cmp({w2_enable, w2_prefetch, w2_addr64}, 3'h6);
    acc(1'b1, 1'b1, 12'h00c, 4'h1, 32'h0000_0000);
    rdc(1'b1, 12'h00c, 32'hffff_f000);
    cmp(w2_prefetch, 1'b0);
    for (int t = 0; t < 4; t++) begin
      wr(1'b1, 12'h014, 32'h8000_0000 | 32'(t << 1));
      cmp({w3_prefetch, w3_addr64}, {1'b0, t == 1});
    end
    wr(1'b1, 12'h014, 32'h7fff_f008);
    cmp({w3_enable, w3_bar_wmask}, 33'h0);
    cmp(w3_prefetch, 1'b1);
  endtask

  task t_translate;
    w3_base_lo = 32'ha000_0000;
    wr(1'b0, 12'h010, 32'h1234_5000);
    wr(1'b1, 12'h014, 32'hfff0_0000);
    xl(32'ha001_2344, 32'h0, 1'b1, 32'h1231_2344);
    xl(32'hb001_2344, 32'h0, 1'b0, 32'hb001_2344);
    xl(32'ha001_2344, 32'h5, 1'b0, 32'ha001_2344);
    wr(1'b1, 12'h014, 32'hfff0_0002);
    wr(1'b0, 12'h018, 32'h8000_000f);
    w3_base_hi = 32'h5;
    xl(32'ha00f_ffff, 32'h5, 1'b1, 32'h123f_ffff);
    xl(32'ha000_0000, 32'h6, 1'b0, 32'ha000_0000);
    xl(32'ha000_0000, 32'h15, 1'b1, 32'h1230_0000);
    wr(1'b1, 12'h014, 32'h7ff0_0002);
    xl(32'ha001_2344, 32'h5, 1'b0, 32'ha001_2344);
  endtask

  // both ports in one cycle: primary must go first, secondary must still land
  task t_both_ports;
    @(negedge clk);
    {pri_req, pri_write, pri_addr, pri_be} = {1'b1, 1'b0, 12'h014, 4'hf};
    {sec_req, sec_write, sec_addr, sec_be, sec_wdata} = {1'b1, 1'b1, 12'h018, 4'hf, 32'h3};
    @(negedge clk);
    cmp({pri_ack, sec_ack, pri_rdata}, {2'h2, 32'h7ff0_0002});
    pri_req = 1'b0;
    @(negedge clk);
    cmp(sec_ack, 1'b1);
    sec_req = 1'b0;
    rdc(1'b0, 12'h018, 32'h0000_0003);
  endtask

  initial begin
    {clk, rst, pri_req, pri_write, sec_req, sec_write, xl_valid} = 7'h20;
    {pri_addr, sec_addr, pri_be, sec_be} = '0;
    {pri_wdata, sec_wdata, xl_addr_lo, xl_addr_hi, w3_base_lo, w3_base_hi} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset_values();
    t_port_access();
    t_setup_fields();
    t_translate();
    t_both_ports();
    test_done();
  end

  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule
